// ===== gpx_port.v
// 8-bit gpio port with edge interrupts, alternate functions and axi4-lite registers
// assumes pins arrive asynchronous to aclk and peripheral controls are synchronous
`timescale 1ns/1ns
`include "gpx_regs.vh"
module gpx_port (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // pins
  input wire [7:0] pin_in,
  output wire [7:0] pin_out,
  output wire [7:0] pin_oe,
  // alternate function from on-chip peripherals
  input wire [7:0] alt_sel,
  input wire [7:0] alt_drive,
  input wire [7:0] alt_out,
  input wire [7:0] alt_open_drain,
  output wire [7:0] alt_in,
  // converter channel routing
  input wire adc_enable,
  input wire [2:0] adc_channel,
  output wire [7:0] adc_route,
  // interrupts
  output wire ext_irq_group_a,
  output wire ext_irq_group_b,
  output wire irq
);
  // software-visible state
  reg [7:0] port_value_reg;
  reg [7:0] dir_reg;
  reg [7:0] ext_irq_enable_reg;
  reg [7:0] open_drain_reg;
  reg [7:0] irq_status;
  // write channel holding registers, either may arrive first
  reg aw_held;
  reg w_held;
  reg [4:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire [7:0] pin_sync;
  wire [7:0] edge_evt;
  wire [7:0] eff_out_mode;
  wire [7:0] eff_open_drain;
  wire [7:0] eff_level;
  wire [7:0] value_read;
  wire do_write;
  wire do_read;
  wire [7:0] clear_bits;
  reg [31:0] next_rdata;
  reg next_rerr;
  reg next_werr;

  // pin levels into the clock domain
  gpx_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw(pin_in),
    .synced(pin_sync)
  );

  // alternate function overrides ordinary direction whenever alt_sel selects the pin, driving or not
  assign eff_out_mode = (alt_sel & alt_drive) | (~alt_sel & dir_reg);
  assign eff_open_drain = (alt_sel & alt_open_drain) | (~alt_sel & open_drain_reg);
  assign eff_level = (alt_sel & alt_out) | (~alt_sel & port_value_reg);

  // open-drain drives only low; push-pull drives both levels
  assign pin_out = eff_level & ~eff_open_drain;
  assign pin_oe = eff_out_mode & ~(eff_open_drain & eff_level);

  // peripheral inputs see the synchronised pin level
  assign alt_in = pin_sync;

  // converter mux: one-hot route of the selected channel
  assign adc_route = adc_enable ? (8'h01 << adc_channel) : 8'h00;

  // read value: pin level for inputs and open-drain outputs, latch otherwise
  assign value_read = (eff_out_mode & ~eff_open_drain & port_value_reg) |
                      (~(eff_out_mode & ~eff_open_drain) & pin_sync);

  // edges on input pins with enable set; output pins never arm
  gpx_edge u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(pin_sync),
    .armed(ext_irq_enable_reg & ~eff_out_mode),
    .event_pulse(edge_evt)
  );

  // external request per vector group is the OR of its pending pins
  assign ext_irq_group_a = |(irq_status & ext_irq_enable_reg & `GPX_GROUP_A);
  assign ext_irq_group_b = |(irq_status & ext_irq_enable_reg & `GPX_GROUP_B);
  assign irq = |(irq_status & ext_irq_enable_reg);

  // axi handshakes: accept each write channel once, reads when idle
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && !s_axi_rvalid;
  assign clear_bits = (do_write && aw_addr == `GPX_OFS_IRQ_CLEAR && w_strb[0]) ?
                      w_data[7:0] : 8'h00;

  // read decode
  always @* begin
    next_rdata = 32'h00000000;
    next_rerr = 1'b0;
    case (s_axi_araddr)
      `GPX_OFS_VALUE: next_rdata[7:0] = value_read;
      `GPX_OFS_DIR: next_rdata[7:0] = dir_reg;
      `GPX_OFS_IRQ_EN: next_rdata[7:0] = ext_irq_enable_reg;
      `GPX_OFS_OPEN_DRAIN: next_rdata[7:0] = open_drain_reg;
      `GPX_OFS_IRQ_STATUS: next_rdata[7:0] = irq_status;
      `GPX_OFS_IRQ_CLEAR: next_rdata[7:0] = 8'h00;
      `GPX_OFS_PIN_LEVEL: next_rdata[7:0] = pin_sync;
      default: next_rerr = 1'b1;
    endcase
  end

  // write decode error check
  always @* begin
    case (aw_addr)
      `GPX_OFS_VALUE, `GPX_OFS_DIR, `GPX_OFS_IRQ_EN, `GPX_OFS_OPEN_DRAIN,
      `GPX_OFS_IRQ_CLEAR: next_werr = 1'b0;
      `GPX_OFS_IRQ_STATUS, `GPX_OFS_PIN_LEVEL: next_werr = 1'b0;
      default: next_werr = 1'b1;
    endcase
  end

  // write channel capture and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GPX_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[4:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= next_werr ? `GPX_RESP_SLVERR : `GPX_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register file; value latch updates regardless of direction
  always @(posedge aclk) begin
    if (!aresetn) begin
      port_value_reg <= `GPX_RST_VALUE;
      dir_reg <= `GPX_RST_DIR;
      ext_irq_enable_reg <= `GPX_RST_IRQ_EN;
      open_drain_reg <= `GPX_RST_OPEN_DRAIN;
    end else if (do_write && w_strb[0]) begin
      case (aw_addr)
        `GPX_OFS_VALUE: port_value_reg <= w_data[7:0];
        `GPX_OFS_DIR: dir_reg <= w_data[7:0];
        `GPX_OFS_IRQ_EN: ext_irq_enable_reg <= w_data[7:0];
        `GPX_OFS_OPEN_DRAIN: open_drain_reg <= w_data[7:0];
        default: port_value_reg <= port_value_reg;
      endcase
    end
  end

  // sticky event status; a new edge wins over a clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn)
      irq_status <= 8'h00;
    else
      irq_status <= (irq_status & ~clear_bits) | edge_evt;
  end

  // read response registered, one cycle after address acceptance
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `GPX_RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rerr ? `GPX_RESP_SLVERR : `GPX_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ===== gpx_regs.vh
// register map, field layout and reset values of the 8-bit gpio port
// assumes an axi4-lite slave with 32-bit data, byte addresses below
//
// Contract
// - eight pins, each configured by its own direction bit, same bit as value.
// - direction 0 means input, direction 1 means output.
// - input pin reads back the current external pin level.
// - each enabled input pin may raise an external interrupt on its own.
// - requests of one vector group are ORed together.
// - pins 1,2,5,6 trigger on rising edges; 3,4,7,8 on falling edges.
// - in output mode the written value is latched and driven to the pin.
// - in output mode a read returns the latch, not the pin.
// - open-drain output pins read back the actual pin level.
// - writing value always updates the latch, even on input pins.
// - an output pin never raises an external interrupt.
// - a peripheral using a pin overrides direction and value settings.
// - a peripheral output forces output mode, push-pull or open-drain as asked.
// - peripheral inputs use input pins; pin level stays readable through value.
// - analog pins are floating inputs; converter mux routes selected pin. Routing leaves pin_oe unchanged; the pin is not forced to input.
`ifndef GPX_REGS_VH
`define GPX_REGS_VH

`define GPX_WIDTH 8
`define GPX_OFS_VALUE 5'h00
`define GPX_OFS_DIR 5'h04
`define GPX_OFS_IRQ_EN 5'h08
`define GPX_OFS_OPEN_DRAIN 5'h0c
`define GPX_OFS_IRQ_STATUS 5'h10
`define GPX_OFS_IRQ_CLEAR 5'h14
`define GPX_OFS_PIN_LEVEL 5'h18
`define GPX_RST_VALUE 8'h00
`define GPX_RST_DIR 8'h00
`define GPX_RST_IRQ_EN 8'h00
`define GPX_RST_OPEN_DRAIN 8'h00
// bit i set: pin i interrupts on a rising edge, else on a falling edge
`define GPX_RISE_MASK 8'h33
// pins 0..3 share one vector group, pins 4..7 the other
`define GPX_GROUP_A 8'h0f
`define GPX_GROUP_B 8'hf0
`define GPX_RESP_OKAY 2'b00
`define GPX_RESP_SLVERR 2'b10

`endif

// ===== gpx_sync.v
// two-flop synchroniser for the eight pin input levels
// assumes pins may change at any time relative to aclk
`timescale 1ns/1ns
`include "gpx_regs.vh"
module gpx_sync (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // raw and synchronised levels
  input wire [`GPX_WIDTH-1:0] raw,
  output reg [`GPX_WIDTH-1:0] synced
);
  reg [`GPX_WIDTH-1:0] stage1;

  // first stage is read only by the second stage
  always @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= 8'h00;
      synced <= 8'h00;
    end else begin
      stage1 <= raw;
      synced <= stage1;
    end
  end
endmodule

// ===== gpx_edge.v
// per-pin edge detector producing one-cycle event pulses
// assumes synchronised inputs; polarity is fixed per pin
`timescale 1ns/1ns
`include "gpx_regs.vh"
module gpx_edge (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // qualified level and resulting pulses
  input wire [`GPX_WIDTH-1:0] level,
  input wire [`GPX_WIDTH-1:0] armed,
  output wire [`GPX_WIDTH-1:0] event_pulse
);
  reg [`GPX_WIDTH-1:0] last;

  // remember previous level
  always @(posedge aclk) begin
    if (!aresetn)
      last <= 8'h00;
    else
      last <= level;
  end

  // rising on masked pins, falling elsewhere; only armed pins count
  assign event_pulse = armed & ((`GPX_RISE_MASK & level & ~last) |
                                (~`GPX_RISE_MASK & ~level & last));
endmodule

// ===== gpx_pin_model.sv
// pad model for the eight port pins
// assumes the outside world drives every pad weakly; device wins where enabled
`timescale 1ns/1ns
module gpx_pin_model (
  // device side
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  // outside level and resolved pad
  input wire [7:0] ext_level,
  output wire [7:0] pin_in
);
  // released pads, open-drain highs too, follow the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ===== gpx_port_props.sv
// port-level checker for gpx_port
// assumes one clock aclk and synchronous active-low aresetn
`timescale 1ns/1ns
module gpx_port_props (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // read and write handshakes
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_bvalid,
  // pins and peripherals
  input wire [7:0] pin_in,
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  input wire [7:0] alt_sel,
  input wire [7:0] alt_drive,
  input wire [7:0] alt_out,
  input wire [7:0] alt_open_drain,
  input wire [7:0] alt_in,
  input wire adc_enable,
  input wire [2:0] adc_channel,
  input wire [7:0] adc_route,
  // interrupts
  input wire ext_irq_group_a,
  input wire ext_irq_group_b,
  input wire irq
);
  wire [7:0] pp = alt_sel & alt_drive & ~alt_open_drain;
  wire [7:0] od = alt_sel & alt_drive & alt_open_drain;
  reg [1:0] age;
  // cycles since reset, so that $past never looks into the reset
  always @(posedge aclk) begin
    if (!aresetn) age <= 2'h0;
    else if (age != 2'h3) age <= age + 2'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_alt_push: assert property ((pin_oe & pp) == pp && (pin_out & pp) == (alt_out & pp))
    else $error("push-pull peripheral drive wrong");
  a_alt_open: assert property ((pin_oe & od) == (~alt_out & od) && (pin_out & od) == 8'h00)
    else $error("open-drain peripheral drive wrong");
  a_alt_input: assert property ((pin_oe & alt_sel & ~alt_drive) == 8'h00)
    else $error("peripheral input pin driven");
  a_irq_or: assert property (irq == (ext_irq_group_a | ext_irq_group_b))
    else $error("irq not the or of the groups");
  a_irq_fall: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
    else $error("irq dropped without a write");
  a_adc_route: assert property (adc_route == (adc_enable ? 8'h01 << adc_channel : 8'h00))
    else $error("converter route wrong");
  a_sync_level: assert property (age == 2'h3 |-> alt_in == $past(pin_in, 2)
    || alt_in == $past(pin_in, 3)) else $error("pin level not synced");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  c_irq: cover property ($rose(irq));
  c_open: cover property (od != 8'h00);
  c_read: cover property (s_axi_rvalid);
endmodule
bind gpx_port gpx_port_props u_props (.*);

// ===== gpio_port_with_edge_irq_tb_top.sv
// self-checking bench for gpx_port
// assumes pad model on the pins; bench drives bus and peripheral inputs
`timescale 1ns/1ns
`include "gpx_regs.vh"
module gpio_port_with_edge_irq_tb_top;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [4:0] awa = 5'h00, ara = 5'h00, a;
  reg awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, aen = 1'b0, ta, tw, dn;
  reg [31:0] wd = 32'h0;
  reg [7:0] ext = 8'h00, as = 8'h00, adr = 8'h00, ao = 8'h00, aod = 8'h00, v, d, o, e, rd;
  reg [2:0] ach = 3'h0;
  reg [1:0] rsp;
  wire awr, wr_ok, bv, arr, rv, ga, gb, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] pin_in, pin_out, pin_oe, alt_in, route;
  integer n_errors = 0, n_tests = 0, i;
  always #4 aclk = ~aclk;
  gpx_port u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
    .s_axi_wready(wr_ok), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .alt_sel(as), .alt_drive(adr), .alt_out(ao),
    .alt_open_drain(aod), .alt_in(alt_in), .adc_enable(aen), .adc_channel(ach),
    .adc_route(route), .ext_irq_group_a(ga), .ext_irq_group_b(gb), .irq(irq));
  gpx_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
  // expected pad level from drive enables and the outside level
  function [7:0] pad(input [7:0] oe, input [7:0] out, input [7:0] x);
    pad = (oe & out) | (~oe & x);
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // handshakes are judged at the negedge, acted on at the next rising edge
  task wrr(input [4:0] ad, input [7:0] dt);
    begin
      dn = 1'b0;
      @(posedge aclk);
      awa <= ad;
      wd <= {24'h0, dt};
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      while (!dn) begin
        @(negedge aclk);
        ta = awv & awr;
        tw = wv & wr_ok;
        dn = bv;
        rsp = bresp;
        @(posedge aclk);
        if (ta) awv <= 1'b0;
        if (tw) wv <= 1'b0;
        if (dn) br <= 1'b0;
      end
    end
  endtask
  task rdr(input [4:0] ad);
    begin
      dn = 1'b0;
      @(posedge aclk);
      ara <= ad;
      arv <= 1'b1;
      rr <= 1'b1;
      while (!dn) begin
        @(negedge aclk);
        ta = arv & arr;
        dn = rv;
        rd = rdata[7:0];
        rsp = rresp;
        @(posedge aclk);
        if (ta) arv <= 1'b0;
        if (dn) rr <= 1'b0;
      end
    end
  endtask
  task end_sim;
    begin
      $display("compares %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #400000;
    n_errors = n_errors + 1;
    end_sim;
  end
  initial begin
    i = $urandom(32'haabc);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (a = 5'h00; a < 5'h10; a = a + 5'h04) begin
      rdr(a);
      chk(rd, 8'h00);
    end
    rdr(5'h1c);
    chk({6'h0, rsp}, {6'h0, `GPX_RESP_SLVERR});
    wrr(5'h1c, 8'h5a);
    chk({6'h0, rsp}, {6'h0, `GPX_RESP_SLVERR});
    wrr(`GPX_OFS_IRQ_STATUS, 8'h5a);
    chk({6'h0, rsp}, {6'h0, `GPX_RESP_OKAY});
    $display("test reset done");
    // value always written before direction, as software must
    for (i = 0; i < 8; i = i + 1) begin
      {v, d, o, e} = $urandom;
      if (i < 2) o = i ? 8'hff : 8'h00;
      @(posedge aclk);
      ext <= e;
      wrr(`GPX_OFS_VALUE, v);
      wrr(`GPX_OFS_OPEN_DRAIN, o);
      wrr(`GPX_OFS_DIR, d);
      repeat (4) @(posedge aclk);
      chk(pin_oe, d & ~(o & v));
      chk(pin_out, v & ~o);
      rdr(`GPX_OFS_VALUE);
      chk(rd, (d & ~o & v) | (~(d & ~o) & pad(d & ~(o & v), v & ~o, e)));
    end
    $display("test data path done");
    @(posedge aclk);
    ext <= 8'h00;
    wrr(`GPX_OFS_DIR, 8'h00);
    wrr(`GPX_OFS_OPEN_DRAIN, 8'h00);
    wrr(`GPX_OFS_IRQ_EN, 8'h0f);
    ext <= 8'hff;
    repeat (6) @(posedge aclk);
    rdr(`GPX_OFS_IRQ_STATUS);
    chk(rd, `GPX_RISE_MASK & 8'h0f);
    chk({5'h0, ga, gb, irq}, 8'h05);
    wrr(`GPX_OFS_IRQ_EN, 8'hff);
    ext <= 8'h00;
    repeat (6) @(posedge aclk);
    rdr(`GPX_OFS_IRQ_STATUS);
    chk(rd, (`GPX_RISE_MASK & 8'h0f) | ~`GPX_RISE_MASK);
    chk({5'h0, ga, gb, irq}, 8'h07);
    wrr(`GPX_OFS_IRQ_CLEAR, 8'hff);
    wrr(`GPX_OFS_DIR, 8'hff);
    wrr(`GPX_OFS_VALUE, 8'hff);
    repeat (6) @(posedge aclk);
    rdr(`GPX_OFS_IRQ_STATUS);
    chk(rd, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wrr(`GPX_OFS_DIR, 8'h00);
    repeat (6) @(posedge aclk);
    rdr(`GPX_OFS_IRQ_STATUS);
    chk(rd, ~`GPX_RISE_MASK);
    wrr(`GPX_OFS_IRQ_EN, 8'h00);
    $display("test interrupts done");
    // peripherals take pins over a direction of all inputs
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge aclk);
      {as, adr, ao, aod} <= $urandom;
      {aen, ach} <= 4'($urandom);
      ext <= 8'($urandom);
      repeat (4) @(posedge aclk);
      chk(pin_oe, as & adr & ~(aod & ao));
      chk(pin_out & as, as & ao & ~aod);
      chk(alt_in, pad(as & adr & ~(aod & ao), ao, ext));
      chk(route, aen ? 8'h01 << ach : 8'h00);
    end
    $display("test peripherals done");
    end_sim;
  end
endmodule
